// ===== dv/arm_mod_src.sv
// modulator bit stream source standing in for the three adc front ends
`default_nettype none
module arm_mod_src (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // bit streams, adc1 on bit 0
  output logic [2:0] mod_bit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr_reg; // pseudo random stream state
  // the stream changes every cycle, so a stuck decimator input shows up at compare
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lfsr_reg <= 16'hace1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end
  // each adc gets a different tap mix so the paths are not identical
  assign mod_bit_out = lfsr_reg[2:0] ^ {lfsr_reg[7], lfsr_reg[11], lfsr_reg[14]};
endmodule // arm_mod_src
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the measurement engine and redundancy checker
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import arm_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] mod_bit;
  logic irq;
  logic [31:0] rdv; // last read value
  int n_fail = 0;
  int total_checks = 0;
  int ncyc; // cycles from start to done
  int ps; // chosen path select
  int m;
  arm_top arm_top_inst (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .mod_bit_in(mod_bit), .irq_out(irq));
  arm_mod_src arm_mod_src_inst (.clock_in(clock_in), .rst_in(rst_in), .mod_bit_out(mod_bit));
  // 40 MHz clock
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // compare one value, four-state safe
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer: setup, access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !got; i++) begin
      @(posedge clock_in);
      if (pready === 1'b1) begin
        got = 1;
        rdv = prdata;
      end
    end
    if (!got) begin
      n_fail++;
      $display("BAD pready expected 1 seen 0");
      test_done();
    end
    // the edge that samples pready high ends the transfer
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for the interrupt line, counting cycles, bounded
  task automatic wait_irq();
    ncyc = 0;
    while (ncyc < 40000 && irq !== 1'b1) begin
      @(negedge clock_in);
      ncyc++;
    end
    if (ncyc >= 40000) begin
      n_fail++;
      $display("BAD irq expected 1 seen 0");
      test_done();
    end
  endtask
  // expected conversion time of one command in cycles
  function automatic int exp_cyc(input int md);
    return T_TOTAL_US[md] * CLK_MHZ;
  endfunction
  // checks that a measured time lands on the expected total
  task automatic check_time(input int md);
    check("run time in window", 1, (ncyc >= exp_cyc(md) - 10) && (ncyc <= exp_cyc(md) + 20));
  endtask
  initial begin
    void'($urandom(25));
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    // reset values and an unmapped place
    apb(1'b0, OFF_CFG, 32'h0); check("cfg reset", 32'h0, rdv);
    apb(1'b0, OFF_IRQ_ST, 32'h0); check("irq status reset", 32'h0, rdv);
    apb(1'b0, OFF_IRQ_MSK, 32'h0); check("irq mask reset", 32'h0, rdv);
    apb(1'b1, 8'h20, $urandom);
    apb(1'b0, 8'h20, 32'h0); check("unmapped read", 32'h0, rdv);
    check("slave error", 1'b0, pslverr);
    $display("test reset done");
    // every mode starts a conversion; reset aborts it
    for (m = 0; m < 8; m++) begin
      apb(1'b1, OFF_CMD, (32'h1 << CMD_GO_BIT) | ($urandom % 2) << CMD_CHK_BIT | m);
      apb(1'b0, OFF_BUSY, 32'h0); check("busy state", ST_CONV, rdv[1:0]);
      @(posedge clock_in);
      rst_in <= 1'b1;
      @(posedge clock_in);
      rst_in <= 1'b0;
    end
    $display("test modes done");
    // plain command with force fail set never checks
    apb(1'b1, OFF_CFG, 32'h1 << CFG_FAIL_BIT);
    apb(1'b1, OFF_IRQ_MSK, 32'h1);
    apb(1'b1, OFF_CMD, 32'h1 << CMD_GO_BIT);
    wait_irq(); check_time(0);
    apb(1'b0, OFF_STAT_A0, 32'h0);
    check("sum range", 1, rdv[15:0] <= RESULT_MAX);
    check("temp range", 1, rdv[31:16] <= RESULT_MAX);
    apb(1'b0, OFF_STAT_A1, 32'h0); check("ana range", 1, rdv[15:0] <= RESULT_MAX);
    apb(1'b0, OFF_STAT_B, 32'h0); check("dig range", 1, rdv[15:0] <= RESULT_MAX);
    apb(1'b0, OFF_IRQ_ST, 32'h0); check("plain events", 32'h1, rdv);
    apb(1'b0, OFF_BUSY, 32'h0); check("idle after", ST_IDLE, rdv[1:0]);
    apb(1'b1, OFF_IRQ_ST, 32'h3);
    $display("test plain done");
    // checked command on path 0 or 1 with force fail: every result faults
    ps = $urandom % 2;
    apb(1'b1, OFF_CFG, (32'h1 << CFG_FAIL_BIT) | ps);
    apb(1'b1, OFF_CMD, (32'h1 << CMD_GO_BIT) | (32'h1 << CMD_CHK_BIT));
    wait_irq(); check_time(0);
    apb(1'b0, OFF_STAT_A0, 32'h0); check("sum temp fault", 32'hff01ff01, rdv);
    apb(1'b0, OFF_STAT_A1, 32'h0); check("ana fault", 16'hff01, rdv[15:0]);
    apb(1'b0, OFF_STAT_B, 32'h0); check("dig fault", 16'hff01, rdv[15:0]);
    apb(1'b0, OFF_IRQ_ST, 32'h0); check("checked events", 32'h3, rdv);
    $display("test checked done");
    // interrupt masking and clearing
    apb(1'b1, OFF_IRQ_MSK, 32'h0);
    repeat (2) @(negedge clock_in);
    check("irq masked", 1'b0, irq);
    apb(1'b1, OFF_IRQ_MSK, 32'h2);
    repeat (2) @(negedge clock_in);
    check("irq fault unmasked", 1'b1, irq);
    apb(1'b1, OFF_IRQ_ST, 32'h2);
    repeat (2) @(negedge clock_in);
    check("irq cleared", 1'b0, irq);
    apb(1'b0, OFF_IRQ_ST, 32'h0); check("one bit cleared", 32'h1, rdv);
    $display("test irq done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire

// ===== hw/arm_pkg.sv
// package for the internal parameter measurement and redundancy checker
`default_nettype none
package arm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;      // command/start
  localparam logic [7:0] OFF_CFG = 8'h04;      // path select, force fail
  localparam logic [7:0] OFF_STAT_A0 = 8'h08;  // stack sum | die temp
  localparam logic [7:0] OFF_STAT_A1 = 8'h0c;  // analog supply
  localparam logic [7:0] OFF_STAT_B = 8'h10;   // digital supply
  localparam logic [7:0] OFF_BUSY = 8'h14;     // busy and phase
  localparam logic [7:0] OFF_IRQ_ST = 8'h18;   // sticky events
  localparam logic [7:0] OFF_IRQ_MSK = 8'h1c;  // mask
  // field layout in the command and config registers
  localparam int CMD_MODE_LSB = 0;   // 3 bit mode
  localparam int CMD_CHK_BIT = 3;    // 1 = checked variant
  localparam int CMD_GO_BIT = 4;     // 1 = start
  localparam int CFG_FAIL_BIT = 2;   // force_redundancy_fail
  // fault code prefix and result ceiling
  localparam logic [11:0] FAULT_HI = 12'hff0;
  localparam logic [15:0] RESULT_MAX = 16'hdfff;
  // timing: total time per mode in us, cycles at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int T_TOTAL_US [8] = '{742, 858, 1556, 2022, 2953, 4814, 8538, 134211};
  localparam int NUM_QTY = 4;
  // events
  localparam int EV_DONE = 0;
  localparam int EV_FAULT = 1;
  // quantity index
  typedef enum logic [1:0] {
    QTY_SUM = 2'b00,
    QTY_TEMP = 2'b01,
    QTY_ANA = 2'b10,
    QTY_DIG = 2'b11
  } arm_qty_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_STORE = 2'b10
  } arm_state_t;
  // results grouped
  typedef struct packed {
    logic [15:0] sum;
    logic [15:0] temp;
    logic [15:0] ana;
    logic [15:0] dig;
  } arm_results_t;
  // whole state of the block
  typedef struct packed {
    arm_state_t st;
    logic [2:0] mode;
    logic chk;
    arm_qty_t qty;
    logic [23:0] cnt;
    logic [15:0] acc_p;
    logic [15:0] acc_r;
    arm_results_t res;
    logic [1:0] path_sel;
    logic force_fail;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic [31:0] prdata;
    logic pready;
    logic irq;
    logic [1:0] auto_path;
  } arm_state_all_t;
endpackage : arm_pkg
`default_nettype wire

// ===== hw/arm_top.sv
// internal parameter measurement engine with redundant decimator check
`default_nettype none
module arm_top
  import arm_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // modulator bit streams of the three adcs
  input wire logic [2:0] mod_bit_in,
  // interrupt
  output logic irq_out
);
  // cycles per quantity for each mode
  function automatic logic [23:0] qty_cycles(input logic [2:0] m);
    int t;
    t = T_TOTAL_US[m] * CLK_MHZ / NUM_QTY;
    return t[23:0];
  endfunction

  // nibble compare yields the fault code low bits
  function automatic logic [3:0] nib_diff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] x;
    x = a ^ b;
    return {|x[15:12], |x[11:8], |x[7:4], |x[3:0]};
  endfunction

  arm_state_all_t s_reg; // all state
  arm_state_all_t s_next; // next state
  logic wr_acc; // apb write access phase
  logic rd_acc; // apb read access phase
  logic prim_bit; // bit of the measuring path
  logic red_bit; // bit seen by redundant machine
  logic [15:0] p_res; // primary clipped result
  logic [15:0] r_res; // redundant clipped result
  logic [3:0] diff; // fault nibble flags
  logic use_chk; // check is applied for this run
  logic [1:0] eff_path; // path under check

  assign wr_acc = psel_in & penable_in & pwrite_in & ~s_reg.pready;
  assign rd_acc = psel_in & penable_in & ~pwrite_in & ~s_reg.pready;
  // internal parameters always run on adc1 (index 0)
  assign prim_bit = mod_bit_in[0];
  assign eff_path = (s_reg.path_sel == 2'h0) ? s_reg.auto_path : s_reg.path_sel;
  // redundancy available only when path is 0 or 1 (adc1)
  assign use_chk = s_reg.chk & (s_reg.path_sel <= 2'h1);
  assign red_bit = mod_bit_in[0];
  assign p_res = (s_reg.acc_p > RESULT_MAX) ? RESULT_MAX : s_reg.acc_p;
  assign r_res = (s_reg.acc_r > RESULT_MAX) ? RESULT_MAX : s_reg.acc_r;
  always_comb begin
    diff = nib_diff(p_res, r_res);
    if (s_reg.force_fail && diff == 4'h0) begin
      diff = 4'h1;
    end
  end

  // next state logic
  always_comb begin
    logic [15:0] val;
    logic [1:0] ev;
    val = 16'h0000;
    ev = 2'b00;
    s_next = s_reg;
    s_next.pready = 1'b0;
    // apb access answers one cycle after access phase begins
    if (rd_acc || wr_acc) begin
      s_next.pready = 1'b1;
    end
    // register reads
    if (rd_acc) begin
      if (paddr_in == OFF_CFG) begin
        s_next.prdata = {29'h0, s_reg.force_fail, s_reg.path_sel};
      end else if (paddr_in == OFF_STAT_A0) begin
        s_next.prdata = {s_reg.res.temp, s_reg.res.sum};
      end else if (paddr_in == OFF_STAT_A1) begin
        s_next.prdata = {16'h0, s_reg.res.ana};
      end else if (paddr_in == OFF_STAT_B) begin
        s_next.prdata = {16'h0, s_reg.res.dig};
      end else if (paddr_in == OFF_BUSY) begin
        s_next.prdata = {28'h0, s_reg.qty, s_reg.st};
      end else if (paddr_in == OFF_IRQ_ST) begin
        s_next.prdata = {30'h0, s_reg.irq_st};
      end else if (paddr_in == OFF_IRQ_MSK) begin
        s_next.prdata = {30'h0, s_reg.irq_msk};
      end else begin
        s_next.prdata = 32'h0; // unmapped and command read zero
      end
    end
    // configuration writes
    if (wr_acc) begin
      if (paddr_in == OFF_CFG) begin
        s_next.path_sel = pwdata_in[1:0];
        s_next.force_fail = pwdata_in[CFG_FAIL_BIT];
      end else if (paddr_in == OFF_IRQ_MSK) begin
        s_next.irq_msk = pwdata_in[1:0];
      end
    end
    // conversion sequencer
    case (s_reg.st)
      ST_IDLE: begin
        if (wr_acc && paddr_in == OFF_CMD && pwdata_in[CMD_GO_BIT]) begin
          s_next.st = ST_CONV;
          s_next.mode = pwdata_in[CMD_MODE_LSB +: 3];
          s_next.chk = pwdata_in[CMD_CHK_BIT];
          s_next.qty = QTY_SUM;
          s_next.cnt = qty_cycles(pwdata_in[CMD_MODE_LSB +: 3]);
          s_next.acc_p = 16'h0000;
          s_next.acc_r = 16'h0000;
        end
      end
      ST_CONV: begin
        // primary and redundant integrators count ones of the stream
        if (s_reg.acc_p != 16'hffff) begin
          s_next.acc_p = s_reg.acc_p + {15'h0, prim_bit};
        end
        if (s_reg.acc_r != 16'hffff) begin
          s_next.acc_r = s_reg.acc_r + {15'h0, red_bit};
        end
        s_next.cnt = s_reg.cnt - 24'h1;
        if (s_reg.cnt == 24'h1) begin
          s_next.st = ST_STORE;
        end
      end
      ST_STORE: begin
        // one cycle write of a full 16-bit value
        if (use_chk && diff != 4'h0) begin
          val = {FAULT_HI, diff};
          ev[EV_FAULT] = 1'b1;
        end else begin
          val = p_res;
        end
        case (s_reg.qty)
          QTY_SUM: s_next.res.sum = val;
          QTY_TEMP: s_next.res.temp = val;
          QTY_ANA: s_next.res.ana = val;
          default: s_next.res.dig = val;
        endcase
        s_next.acc_p = 16'h0000;
        s_next.acc_r = 16'h0000;
        if (s_reg.qty == QTY_DIG) begin
          s_next.st = ST_IDLE;
          ev[EV_DONE] = 1'b1;
          s_next.auto_path = s_reg.auto_path + 2'h1;
          if (s_reg.auto_path == 2'h3) begin
            s_next.auto_path = 2'h1;
          end
        end else begin
          s_next.qty = arm_qty_t'(s_reg.qty + 2'h1);
          s_next.cnt = qty_cycles(s_reg.mode) - 24'h1; // store cycle counted
          s_next.st = ST_CONV;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
    // sticky flags: write one clears, set wins
    if (wr_acc && paddr_in == OFF_IRQ_ST) begin
      s_next.irq_st = s_reg.irq_st & ~pwdata_in[1:0];
    end
    s_next.irq_st = s_next.irq_st | ev;
    s_next.irq = |(s_next.irq_st & s_next.irq_msk);
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.auto_path <= 2'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_out = s_reg.prdata;
  assign pready_out = s_reg.pready;
  assign pslverr_out = 1'b0;
  assign irq_out = s_reg.irq;

  // checks
  // a fault store must raise the fault event, whatever the old register held
  property p_fault_low;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && diff != 4'h0) |=> s_reg.irq_st[EV_FAULT];
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault not stored");

  property p_force;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && s_reg.force_fail) |-> (diff != 4'h0);
  endproperty
  a_force: assert property (p_force) else $error("force fail ignored");

  property p_plain;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && !s_reg.chk && !s_reg.irq_st[EV_FAULT]) |=> !s_reg.irq_st[EV_FAULT];
  endproperty
  a_plain: assert property (p_plain) else $error("plain command flagged fault");

  sequence s_start;
    s_reg.st == ST_IDLE && wr_acc && paddr_in == OFF_CMD && pwdata_in[CMD_GO_BIT];
  endsequence
  property p_enter;
    @(posedge clock_in) disable iff (rst_in)
      s_start |=> (s_reg.st == ST_CONV && s_reg.qty == QTY_SUM && s_reg.cnt == qty_cycles(s_reg.mode));
  endproperty
  a_enter: assert property (p_enter) else $error("start not taken");

  property p_clip;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && !(use_chk && diff != 4'h0)) |=> (s_reg.res.sum <= RESULT_MAX);
  endproperty
  a_clip: assert property (p_clip) else $error("result above range");

  property p_last;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && s_reg.qty == QTY_DIG) |=> (s_reg.st == ST_IDLE && s_reg.irq_st[EV_DONE]);
  endproperty
  a_last: assert property (p_last) else $error("done not flagged");

  property p_ready;
    @(posedge clock_in) disable iff (rst_in)
      (psel_in && penable_in && !s_reg.pready) |=> s_reg.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb not answered");

  property p_irq;
    @(posedge clock_in) disable iff (rst_in)
      s_reg.irq == |(s_reg.irq_st & s_reg.irq_msk);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  // store of a quantity that is not the last one
  sequence s_mid_store;
    s_reg.st == ST_STORE && s_reg.qty != QTY_DIG;
  endsequence

  // a faulty stack sum lands as the fault code with the nibble flags
  property p_fault_sum;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && diff != 4'h0 && s_reg.qty == QTY_SUM)
        |=> (s_reg.res.sum == {FAULT_HI, $past(diff)});
  endproperty
  a_fault_sum: assert property (p_fault_sum) else $error("sum fault code wrong");

  // same for the die temperature slot
  property p_fault_temp;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && diff != 4'h0 && s_reg.qty == QTY_TEMP)
        |=> (s_reg.res.temp == {FAULT_HI, $past(diff)});
  endproperty
  a_fault_temp: assert property (p_fault_temp) else $error("temp fault code wrong");

  // same for the analog supply slot
  property p_fault_ana;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && diff != 4'h0 && s_reg.qty == QTY_ANA)
        |=> (s_reg.res.ana == {FAULT_HI, $past(diff)});
  endproperty
  a_fault_ana: assert property (p_fault_ana) else $error("ana fault code wrong");

  // same for the digital supply slot
  property p_fault_dig;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && use_chk && diff != 4'h0 && s_reg.qty == QTY_DIG)
        |=> (s_reg.res.dig == {FAULT_HI, $past(diff)});
  endproperty
  a_fault_dig: assert property (p_fault_dig) else $error("dig fault code wrong");

  // no slot may ever hold the fault prefix with an all zero low nibble
  property p_no_zero;
    @(posedge clock_in) disable iff (rst_in)
      s_reg.st == ST_STORE |=> (s_reg.res.sum != {FAULT_HI, 4'h0})
        && (s_reg.res.temp != {FAULT_HI, 4'h0}) && (s_reg.res.ana != {FAULT_HI, 4'h0})
        && (s_reg.res.dig != {FAULT_HI, 4'h0});
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("zero fault nibble stored");

  // the per quantity counter steps down once a cycle while converting
  property p_cnt_down;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_CONV && s_reg.cnt != 24'h1)
        |=> (s_reg.st == ST_CONV && s_reg.cnt == $past(s_reg.cnt) - 24'h1);
  endproperty
  a_cnt_down: assert property (p_cnt_down) else $error("counter did not step");

  // the last counted cycle hands over to the store cycle
  property p_conv_end;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_CONV && s_reg.cnt == 24'h1) |=> s_reg.st == ST_STORE;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("conversion did not end");

  // after a middle store the next quantity starts with the store cycle already counted
  property p_next_qty;
    @(posedge clock_in) disable iff (rst_in)
      s_mid_store |=> (s_reg.st == ST_CONV && s_reg.qty == arm_qty_t'($past(s_reg.qty) + 2'h1)
        && s_reg.cnt == qty_cycles(s_reg.mode) - 24'h1);
  endproperty
  a_next_qty: assert property (p_next_qty) else $error("next quantity not started");

  // a start while busy is refused, the running mode stays
  property p_busy_ignore;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st != ST_IDLE && wr_acc && paddr_in == OFF_CMD) |=> s_reg.mode == $past(s_reg.mode);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy start taken");

  // configuration writes land in the path select and force fail bits
  property p_cfg_write;
    @(posedge clock_in) disable iff (rst_in)
      (wr_acc && paddr_in == OFF_CFG) |=> (s_reg.path_sel == $past(pwdata_in[1:0])
        && s_reg.force_fail == $past(pwdata_in[CFG_FAIL_BIT]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  // both integrators start from zero on a new command
  property p_acc_clear;
    @(posedge clock_in) disable iff (rst_in)
      s_start |=> (s_reg.acc_p == 16'h0000 && s_reg.acc_r == 16'h0000);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("integrators not cleared");

  // result slots only change in the single store cycle, so reads never see a half value
  property p_res_stable;
    @(posedge clock_in) disable iff (rst_in)
      s_reg.st != ST_STORE |=> s_reg.res == $past(s_reg.res);
  endproperty
  a_res_stable: assert property (p_res_stable) else $error("result changed outside store");

  // the automatic choice never rests on the reserved code
  property p_auto;
    @(posedge clock_in) disable iff (rst_in)
      s_reg.auto_path != 2'h0;
  endproperty
  a_auto: assert property (p_auto) else $error("auto path invalid");

  // an unmasked done event raises the interrupt on the next cycle
  property p_done_irq;
    @(posedge clock_in) disable iff (rst_in)
      (s_reg.st == ST_STORE && s_reg.qty == QTY_DIG && s_reg.irq_msk[EV_DONE]) |=> s_reg.irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done irq missing");
endmodule : arm_top
`default_nettype wire
